/* File: src/spf_pkg.sv */
// Package for the sensor port pin-function select block.
// Assumes one 25 MHz system clock and plain control ports.
package spf_pkg;

    // ------------------------------------------------------------
    // Constants
    // ------------------------------------------------------------
    localparam int   CLK_HZ      = 25_000_000;
    localparam int   WAKE_BITS   = 4;
    localparam logic PIN_IDLE    = 1'b0;
    localparam logic SYNC_RST    = 1'b0;
    // SPI input register after reset: select high, clock and data low
    localparam logic [2:0] SPI_IN_IDLE = 3'h2;

    // Port B line 1 function select
    typedef enum logic [1:0] {
        SPF_B1_GPIO,
        SPF_B1_TIMER,
        SPF_B1_ADC
    } spf_b1_fn_e;

    // Port A line function select (when SPI off)
    typedef enum logic [1:0] {
        SPF_A_GPIO,
        SPF_A_WAKE,
        SPF_A_IRQ
    } spf_a_fn_e;

    // Per-line GPIO configuration
    typedef struct packed {
        logic dir_out;
        logic out_val;
        logic pull_en;
        logic pull_down;
        logic wake_en;
    } spf_line_cfg_s;

    // Pad control for one line
    typedef struct packed {
        logic oe;
        logic o;
        logic pu;
        logic pd;
    } spf_pad_s;

endpackage

/* File: src/spf_line.sv */
// One port A line: GPIO with pulls and wake gating.
// Assumes the configuration is stable from the system clock.
`timescale 1ns/1ns
module spf_line (
    // Configuration
    input  wire spf_pkg::spf_line_cfg_s cfg_i,
    input  wire logic                   spi_own_i,
    input  wire logic                   spi_oe_i,
    input  wire logic                   spi_o_i,
    // Pad
    input  wire logic                   pad_i,
    output spf_pkg::spf_pad_s           pad_o,
    // Wake
    output logic                        wake_o
);

    // ------------------------------------------------------------
    // Pad drive and pulls
    // ------------------------------------------------------------
    always_comb begin
        if (spi_own_i) begin
            pad_o.oe = spi_oe_i;
            pad_o.o  = spi_o_i;
            pad_o.pu = 1'b0;
            pad_o.pd = 1'b0;
        end else begin
            pad_o.oe = cfg_i.dir_out;
            pad_o.o  = cfg_i.out_val;
            pad_o.pu = cfg_i.pull_en & ~cfg_i.pull_down;
            pad_o.pd = cfg_i.pull_en & cfg_i.pull_down & cfg_i.wake_en;
        end
        wake_o = ~spi_own_i & cfg_i.wake_en & pad_i;
    end

endmodule

/* File: src/spf_top.sv */
// Pin-function select for port A lines 0..3, port B line 1 and LF inputs.
// Assumes synchronous pad inputs and a single system clock.
`timescale 1ns/1ns
module spf_top (
    // Clock and reset
    input  wire logic                   clk_sys_i,
    input  wire logic                   rst_b_i,
    // Control
    input  wire logic                   spi_enable_i,
    input  wire spf_pkg::spf_a_fn_e     a0_fn_i,
    input  wire spf_pkg::spf_a_fn_e     a1_fn_i,
    input  wire spf_pkg::spf_line_cfg_s a0_cfg_i,
    input  wire spf_pkg::spf_line_cfg_s a1_cfg_i,
    input  wire spf_pkg::spf_b1_fn_e    b1_fn_i,
    input  wire logic                   b1_dir_out_i,
    input  wire logic                   b1_out_val_i,
    input  wire logic                   b1_pullup_i,
    input  wire logic                   lowfreq_rx_enable_i,
    // Port A pads
    input  wire logic                   porta_line0_i,
    output logic                        porta_line0_o,
    output logic                        porta_line0_oe_o,
    output logic                        porta_line0_pu_o,
    output logic                        porta_line0_pd_o,
    input  wire logic                   porta_line1_i,
    output logic                        porta_line1_o,
    output logic                        porta_line1_oe_o,
    output logic                        porta_line1_pu_o,
    output logic                        porta_line1_pd_o,
    input  wire logic                   porta_line2_i,
    output logic                        porta_line2_o,
    output logic                        porta_line2_oe_o,
    input  wire logic                   porta_line3_i,
    // Port B line 1 pad
    input  wire logic                   portb_line1_i,
    output logic                        portb_line1_o,
    output logic                        portb_line1_oe_o,
    output logic                        portb_line1_pu_o,
    // Low-frequency receiver inputs
    input  wire logic                   lowfreq_in_pos_i,
    input  wire logic                   lowfreq_in_neg_i,
    output logic                        lowfreq_receiver_pos_o,
    output logic                        lowfreq_receiver_neg_o,
    // SPI client core side
    input  wire logic                   spi_miso_i,
    output logic                        spi_sclk_o,
    output logic                        spi_ss_b_o,
    output logic                        spi_mosi_o,
    // Peripheral side
    output logic [3:0]                  key_wake_input_o,
    output logic                        ext_irq_o,
    output logic                        porta_line0_din_o,
    output logic                        porta_line1_din_o,
    input  wire logic                   timer_pwm_unit_ch1_out_i,
    input  wire logic                   timer_pwm_unit_ch1_oe_i,
    output logic                        timer_pwm_unit_ch1_in_o,
    output logic                        adc_ch4_in_o,
    output logic                        portb_line1_din_o
);

    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    logic rst_meta;
    logic rst_sync;
    logic next_rst_meta;

    always_comb begin
        next_rst_meta = 1'b1;
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rst_meta <= spf_pkg::SYNC_RST;
            rst_sync <= spf_pkg::SYNC_RST;
        end else begin
            rst_meta <= next_rst_meta;
            rst_sync <= rst_meta;
        end
    end

    // ------------------------------------------------------------
    // Function selection state
    // ------------------------------------------------------------
    logic spi_on;
    logic next_spi_on;
    logic lf_on;
    logic next_lf_on;

    always_comb begin
        next_spi_on = spi_enable_i;
        next_lf_on  = lowfreq_rx_enable_i;
    end

    always_ff @(posedge clk_sys_i or negedge rst_sync) begin
        if (!rst_sync) begin
            spi_on <= 1'b0;
            lf_on  <= 1'b0;
        end else begin
            spi_on <= next_spi_on;
            lf_on  <= next_lf_on;
        end
    end

    // ------------------------------------------------------------
    // Port A lines 0 and 1
    // ------------------------------------------------------------
    spf_pkg::spf_pad_s pad0;
    spf_pkg::spf_pad_s pad1;
    logic              wake0;
    logic              wake1;

    spf_line u_line0 (
        .cfg_i     (a0_cfg_i),
        .spi_own_i (spi_on),
        .spi_oe_i  (1'b0),
        .spi_o_i   (1'b0),
        .pad_i     (porta_line0_i),
        .pad_o     (pad0),
        .wake_o    (wake0)
    );

    spf_line u_line1 (
        .cfg_i     (a1_cfg_i),
        .spi_own_i (spi_on),
        .spi_oe_i  (1'b0),
        .spi_o_i   (1'b0),
        .pad_i     (porta_line1_i),
        .pad_o     (pad1),
        .wake_o    (wake1)
    );

    // Registered input routing
    logic [3:0] next_wake;
    logic       next_irq;
    logic       next_din0;
    logic       next_din1;
    logic [2:0] next_spi_in;
    logic [3:0] wake_q;
    logic       irq_q;
    logic       din0_q;
    logic       din1_q;
    logic [2:0] spi_in_q;

    always_comb begin
        next_wake      = '0;
        next_wake[0]   = wake0 & (a0_fn_i == spf_pkg::SPF_A_WAKE);
        next_wake[1]   = wake1 & (a1_fn_i == spf_pkg::SPF_A_WAKE);
        next_irq       = ~spi_on & (a0_fn_i == spf_pkg::SPF_A_IRQ) & porta_line0_i;
        next_din0      = ~spi_on & porta_line0_i;
        next_din1      = ~spi_on & porta_line1_i;
        next_spi_in[0] = spi_on & porta_line1_i;
        next_spi_in[1] = ~spi_on | porta_line0_i;
        next_spi_in[2] = spi_on & porta_line3_i;
    end

    always_ff @(posedge clk_sys_i or negedge rst_sync) begin
        if (!rst_sync) begin
            wake_q   <= '0;
            irq_q    <= 1'b0;
            din0_q   <= 1'b0;
            din1_q   <= 1'b0;
            spi_in_q <= spf_pkg::SPI_IN_IDLE;
        end else begin
            wake_q   <= next_wake;
            irq_q    <= next_irq;
            din0_q   <= next_din0;
            din1_q   <= next_din1;
            spi_in_q <= next_spi_in;
        end
    end

    // Port A line 0/1 pads and inputs
    always_comb begin
        porta_line0_o     = pad0.o;
        porta_line0_oe_o  = pad0.oe;
        porta_line0_pu_o  = pad0.pu;
        porta_line0_pd_o  = pad0.pd;
        porta_line1_o     = pad1.o;
        porta_line1_oe_o  = pad1.oe;
        porta_line1_pu_o  = pad1.pu;
        porta_line1_pd_o  = pad1.pd;
        key_wake_input_o  = wake_q;
        ext_irq_o         = irq_q;
        porta_line0_din_o = din0_q;
        porta_line1_din_o = din1_q;
        spi_sclk_o        = spi_in_q[0];
        spi_ss_b_o        = spi_in_q[1];
        spi_mosi_o        = spi_in_q[2];
    end

    // ------------------------------------------------------------
    // Port A line 2 as MISO
    // ------------------------------------------------------------
    always_comb begin
        porta_line2_oe_o = spi_on & ~spi_ss_b_o;
        porta_line2_o    = spi_on & spi_miso_i;
    end

    // ------------------------------------------------------------
    // Port B line 1 routing
    // ------------------------------------------------------------
    logic next_tin;
    logic next_adc;
    logic next_bdin;
    logic tin_q;
    logic adc_q;
    logic bdin_q;

    always_comb begin
        case (b1_fn_i)
            spf_pkg::SPF_B1_TIMER: begin
                portb_line1_oe_o = timer_pwm_unit_ch1_oe_i;
                portb_line1_o    = timer_pwm_unit_ch1_out_i;
                portb_line1_pu_o = 1'b0;
            end
            spf_pkg::SPF_B1_ADC: begin
                portb_line1_oe_o = 1'b0;
                portb_line1_o    = spf_pkg::PIN_IDLE;
                portb_line1_pu_o = 1'b0;
            end
            default: begin
                portb_line1_oe_o = b1_dir_out_i;
                portb_line1_o    = b1_out_val_i;
                portb_line1_pu_o = b1_pullup_i & ~b1_dir_out_i;
            end
        endcase
        next_tin  = (b1_fn_i == spf_pkg::SPF_B1_TIMER) & portb_line1_i;
        next_adc  = (b1_fn_i == spf_pkg::SPF_B1_ADC) & portb_line1_i;
        next_bdin = (b1_fn_i == spf_pkg::SPF_B1_GPIO) & portb_line1_i;
    end

    always_ff @(posedge clk_sys_i or negedge rst_sync) begin
        if (!rst_sync) begin
            tin_q  <= 1'b0;
            adc_q  <= 1'b0;
            bdin_q <= 1'b0;
        end else begin
            tin_q  <= next_tin;
            adc_q  <= next_adc;
            bdin_q <= next_bdin;
        end
    end

    // ------------------------------------------------------------
    // Low-frequency receiver gating and B1 inputs
    // ------------------------------------------------------------
    always_comb begin
        lowfreq_receiver_pos_o  = lf_on & lowfreq_in_pos_i;
        lowfreq_receiver_neg_o  = lf_on & lowfreq_in_neg_i;
        timer_pwm_unit_ch1_in_o = tin_q;
        adc_ch4_in_o            = adc_q;
        portb_line1_din_o       = bdin_q;
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    property p_pd_gate;
        @(posedge clk_sys_i) disable iff (!rst_sync)
        porta_line0_pd_o |-> (a0_cfg_i.wake_en && !spi_on);
    endproperty
    a_pd_gate: assert property (p_pd_gate) else $error("pull-down without wake enable");

    property p_wake1;
        @(posedge clk_sys_i) disable iff (!rst_sync)
        (!spi_on && a1_cfg_i.wake_en && a1_fn_i == spf_pkg::SPF_A_WAKE && porta_line1_i)
            |=> key_wake_input_o[1];
    endproperty
    a_wake1: assert property (p_wake1) else $error("line1 wake bit missed");

    property p_sclk;
        @(posedge clk_sys_i) disable iff (!rst_sync)
        spi_on |=> (spi_sclk_o == $past(porta_line1_i));
    endproperty
    a_sclk: assert property (p_sclk) else $error("sclk not from line1");

    property p_a0_gpio;
        @(posedge clk_sys_i) disable iff (!rst_sync)
        !spi_on |-> (porta_line0_oe_o == a0_cfg_i.dir_out);
    endproperty
    a_a0_gpio: assert property (p_a0_gpio) else $error("line0 direction wrong");

    property p_irq;
        @(posedge clk_sys_i) disable iff (!rst_sync)
        ext_irq_o |-> $past(a0_fn_i == spf_pkg::SPF_A_IRQ && !spi_on);
    endproperty
    a_irq: assert property (p_irq) else $error("irq from wrong function");

    property p_ss;
        @(posedge clk_sys_i) disable iff (!rst_sync)
        spi_on |=> (spi_ss_b_o == $past(porta_line0_i)) && !key_wake_input_o[0];
    endproperty
    a_ss: assert property (p_ss) else $error("select not from line0");

    property p_b1_adc;
        @(posedge clk_sys_i) disable iff (!rst_sync)
        (b1_fn_i == spf_pkg::SPF_B1_ADC) |-> !portb_line1_oe_o ##1 (adc_ch4_in_o == $past(portb_line1_i));
    endproperty
    a_b1_adc: assert property (p_b1_adc) else $error("adc routing wrong");

    property p_b1_gpio;
        @(posedge clk_sys_i) disable iff (!rst_sync)
        (b1_fn_i == spf_pkg::SPF_B1_GPIO) |-> (portb_line1_oe_o == b1_dir_out_i);
    endproperty
    a_b1_gpio: assert property (p_b1_gpio) else $error("b1 gpio direction wrong");

    property p_lf;
        @(posedge clk_sys_i) disable iff (!rst_sync)
        !lf_on |-> !lowfreq_receiver_pos_o && !lowfreq_receiver_neg_o;
    endproperty
    a_lf: assert property (p_lf) else $error("lf passed while disabled");

    property p_miso;
        @(posedge clk_sys_i) disable iff (!rst_sync)
        !spi_on |-> !porta_line2_oe_o;
    endproperty
    a_miso: assert property (p_miso) else $error("miso driven while spi off");

    property p_restore;
        @(posedge clk_sys_i) disable iff (!rst_sync)
        $fell(spi_on) |-> (porta_line1_oe_o == a1_cfg_i.dir_out) ##1 !spi_sclk_o;
    endproperty
    a_restore: assert property (p_restore) else $error("line1 not restored");

    c_spi:  cover property (@(posedge clk_sys_i) disable iff (!rst_sync) $rose(spi_on));
    c_wake: cover property (@(posedge clk_sys_i) disable iff (!rst_sync) key_wake_input_o[0]);
    c_irq:  cover property (@(posedge clk_sys_i) disable iff (!rst_sync) ext_irq_o);
    c_lf:   cover property (@(posedge clk_sys_i) disable iff (!rst_sync) lowfreq_receiver_pos_o);

endmodule

/* File: sim/spf_far_model.sv */
// Far-side model: SPI host and wake sources on the port pads, LF coil.
// Assumes the bench packs pad controls as bit 0..4 = A0, A1, A2, A3, B1.
`timescale 1ns/1ns
module spf_far_model (
    // Pad controls from the block
    input  wire logic [4:0] oe_i,
    input  wire logic [4:0] o_i,
    input  wire logic [4:0] pu_i,
    input  wire logic [4:0] pd_i,
    // Resolved pad levels
    output logic [4:0]      pad_o,
    // LF coil
    output logic            lf_pos_o,
    output logic            lf_neg_o
);
    logic [4:0] drv_en;
    logic [4:0] drv_val;

    initial begin
        drv_en   = 5'h00;
        drv_val  = 5'h00;
        lf_pos_o = 1'b0;
        lf_neg_o = 1'b0;
    end

    // Wire level: block drive, host drive, pulls, else inverse of last value
    always_comb begin
        for (int i = 0; i < 5; i++) begin
            if (oe_i[i])
                pad_o[i] = o_i[i];
            else if (drv_en[i])
                pad_o[i] = drv_val[i];
            else if (pu_i[i] | pd_i[i])
                pad_o[i] = pu_i[i];
            else
                pad_o[i] = ~drv_val[i];
        end
    end

    // Host or wake source takes the lines: select A0, clock A1, data A3
    task automatic drive(input logic [4:0] en, input logic [4:0] val);
        drv_en  = en;
        drv_val = val;
    endtask

    // Differential coil levels
    task automatic coil(input logic p, input logic n);
        lf_pos_o = p;
        lf_neg_o = n;
    endtask
endmodule

/* File: sim/spf_top_tb.sv */
// Self-checking bench for the pin-function select block.
// Assumes the far-side model resolves every pad wire.
`timescale 1ns/1ns
module spf_top_tb;
    logic clk_sys_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic spi_en = 1'b0, lf_en = 1'b0, miso = 1'b0;
    logic b1_dir = 1'b0, b1_val = 1'b0, b1_pu = 1'b0, tpm_out = 1'b0, tpm_oe = 1'b0;
    spf_pkg::spf_a_fn_e a0_fn = spf_pkg::SPF_A_GPIO, a1_fn = spf_pkg::SPF_A_GPIO;
    spf_pkg::spf_b1_fn_e b1_fn = spf_pkg::SPF_B1_GPIO;
    spf_pkg::spf_line_cfg_s a0_cfg = '0, a1_cfg = '0;
    wire [4:0] oe, po, pu, pd, pad;
    wire lf_p, lf_n, rx_p, rx_n, sclk, ss_b, mosi, irq, din0, din1, b1_din, tpm_in, adc_in;
    wire [3:0] wake;
    int n_fail = 0;
    int checked = 0;

    // Unused pad-control bits
    assign oe[3] = 1'b0;
    assign po[3] = 1'b0;
    assign pu[3:2] = 2'b00;
    assign pd[4:2] = 3'b000;

    // Clock
    always #20 clk_sys_i = ~clk_sys_i;

    spf_top i_dut (
        .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .spi_enable_i(spi_en),
        .a0_fn_i(a0_fn), .a1_fn_i(a1_fn), .a0_cfg_i(a0_cfg), .a1_cfg_i(a1_cfg),
        .b1_fn_i(b1_fn), .b1_dir_out_i(b1_dir), .b1_out_val_i(b1_val), .b1_pullup_i(b1_pu),
        .lowfreq_rx_enable_i(lf_en),
        .porta_line0_i(pad[0]), .porta_line0_o(po[0]), .porta_line0_oe_o(oe[0]),
        .porta_line0_pu_o(pu[0]), .porta_line0_pd_o(pd[0]),
        .porta_line1_i(pad[1]), .porta_line1_o(po[1]), .porta_line1_oe_o(oe[1]),
        .porta_line1_pu_o(pu[1]), .porta_line1_pd_o(pd[1]),
        .porta_line2_i(pad[2]), .porta_line2_o(po[2]), .porta_line2_oe_o(oe[2]),
        .porta_line3_i(pad[3]),
        .portb_line1_i(pad[4]), .portb_line1_o(po[4]), .portb_line1_oe_o(oe[4]), .portb_line1_pu_o(pu[4]),
        .lowfreq_in_pos_i(lf_p), .lowfreq_in_neg_i(lf_n),
        .lowfreq_receiver_pos_o(rx_p), .lowfreq_receiver_neg_o(rx_n),
        .spi_miso_i(miso), .spi_sclk_o(sclk), .spi_ss_b_o(ss_b), .spi_mosi_o(mosi),
        .key_wake_input_o(wake), .ext_irq_o(irq), .porta_line0_din_o(din0), .porta_line1_din_o(din1),
        .timer_pwm_unit_ch1_out_i(tpm_out), .timer_pwm_unit_ch1_oe_i(tpm_oe),
        .timer_pwm_unit_ch1_in_o(tpm_in), .adc_ch4_in_o(adc_in), .portb_line1_din_o(b1_din)
    );

    spf_far_model i_far (
        .oe_i(oe), .o_i(po), .pu_i(pu), .pd_i(pd), .pad_o(pad), .lf_pos_o(lf_p), .lf_neg_o(lf_n)
    );

    // --------------------------------------------------------------
    // Helpers
    // --------------------------------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // Past enable lag and output register, then off the edge
    task automatic settle;
        repeat (3) @(posedge clk_sys_i);
        #2;
    endtask

    // Same line configuration on A0 and A1
    task automatic cfg(input logic d, input logic v, input logic pe, input logic pdn, input logic we);
        a0_cfg = {d, v, pe, pdn, we};
        a1_cfg = {d, v, pe, pdn, we};
        settle();
    endtask

    task automatic finish_test;
        if (n_fail == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // --------------------------------------------------------------
    // Scenarios
    // --------------------------------------------------------------
    task automatic t_pulls;
        i_far.drive(5'h00, 5'h00);
        cfg(1'b0, 1'b0, 1'b1, 1'b1, 1'b0);
        chk(8'(pd[1:0]), 8'h00);
        chk(8'(pu[1:0]), 8'h00);
        cfg(1'b0, 1'b0, 1'b1, 1'b1, 1'b1);
        chk(8'(pd[1:0]), 8'h03);
        chk(8'({din1, din0}), 8'h00);
        cfg(1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
        chk(8'({pu[1:0], pd[1:0]}), 8'h0C);
        chk(8'({din1, din0}), 8'h03);
        cfg(1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
        chk(8'({oe[1:0], po[1:0]}), 8'h0F);
        cfg(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
        chk(8'({oe[1:0], po[1:0]}), 8'h0C);
    endtask

    task automatic t_wake;
        a0_fn = spf_pkg::SPF_A_WAKE;
        a1_fn = spf_pkg::SPF_A_WAKE;
        i_far.drive(5'h03, 5'h01);
        cfg(1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
        chk(8'(wake), 8'h01);
        i_far.drive(5'h03, 5'h02);
        settle();
        chk(8'(wake), 8'h02);
        cfg(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
        chk(8'(wake), 8'h00);
    endtask

    task automatic t_irq;
        a0_fn = spf_pkg::SPF_A_IRQ;
        i_far.drive(5'h01, 5'h01);
        settle();
        chk(8'(irq), 8'h01);
        i_far.drive(5'h01, 5'h00);
        settle();
        chk(8'(irq), 8'h00);
        a0_fn = spf_pkg::SPF_A_GPIO;
        i_far.drive(5'h01, 5'h01);
        settle();
        chk(8'({irq, din0}), 8'h01);
    endtask

    task automatic t_spi;
        a0_fn = spf_pkg::SPF_A_WAKE;
        a1_fn = spf_pkg::SPF_A_WAKE;
        a0_cfg = {1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
        spi_en = 1'b1;
        miso = 1'b1;
        i_far.drive(5'h0B, 5'h0A);
        settle();
        chk(8'({ss_b, sclk, mosi}), 8'h03);
        chk(8'({oe[1:0], pu[1:0], pd[1:0]}), 8'h00);
        chk(8'({oe[2], pad[2]}), 8'h03);
        chk(8'(wake), 8'h00);
        chk(8'({din1, din0}), 8'h00);
        i_far.drive(5'h0B, 5'h01);
        settle();
        chk(8'({ss_b, sclk, mosi}), 8'h04);
        chk(8'(oe[2]), 8'h00);
        spi_en = 1'b0;
        settle();
        chk(8'(pu[0]), 8'h01);
        chk(8'(wake), 8'h01);
    endtask

    task automatic t_b1;
        b1_fn = spf_pkg::SPF_B1_GPIO;
        b1_dir = 1'b1;
        b1_val = 1'b1;
        b1_pu = 1'b1;
        settle();
        chk(8'({oe[4], po[4], pu[4]}), 8'h06);
        b1_dir = 1'b0;
        i_far.drive(5'h00, 5'h00);
        settle();
        chk(8'({pu[4], b1_din}), 8'h03);
        b1_fn = spf_pkg::SPF_B1_TIMER;
        tpm_out = 1'b1;
        tpm_oe = 1'b1;
        settle();
        chk(8'({oe[4], po[4]}), 8'h03);
        tpm_oe = 1'b0;
        i_far.drive(5'h10, 5'h00);
        settle();
        chk(8'({oe[4], tpm_in}), 8'h00);
        i_far.drive(5'h10, 5'h10);
        settle();
        chk(8'({tpm_in, b1_din}), 8'h02);
        b1_fn = spf_pkg::SPF_B1_ADC;
        i_far.drive(5'h10, 5'h10);
        settle();
        chk(8'(adc_in), 8'h01);
    endtask

    task automatic t_lf;
        i_far.coil(1'b1, 1'b0);
        lf_en = 1'b0;
        settle();
        chk(8'({rx_p, rx_n}), 8'h00);
        lf_en = 1'b1;
        settle();
        chk(8'({rx_p, rx_n}), 8'h02);
        i_far.coil(1'b0, 1'b1);
        settle();
        chk(8'({rx_p, rx_n}), 8'h01);
    endtask

    // --------------------------------------------------------------
    // Main sequence and watchdog
    // --------------------------------------------------------------
    initial begin
        repeat (20) @(posedge clk_sys_i);
        #2;
        chk(8'({ss_b, wake}), 8'h10);
        rst_b_i = 1'b1;
        settle();
        t_pulls();
        t_wake();
        t_irq();
        t_spi();
        t_b1();
        t_lf();
        finish_test();
    end

    initial begin
        #(40 * 2000);
        n_fail++;
        finish_test();
    end
endmodule
